/* logic/epf_cfg.svh */
// constants for the ethernet port flow-control block
`ifndef EPF_CFG_SVH
`define EPF_CFG_SVH
`define EPF_PAUSE_DA     48'h0180_6200_0001
`define EPF_JAM_BYTES    3'h4
`define EPF_RUNT_BYTES   16'h0040
`define EPF_MAX_LEN_CAP  16'h07e0
`define EPF_LEN_SAT      16'hffff
`define EPF_DIV10_LAST   3'h4
`define EPF_STRAP_WAIT   2'h3
`endif

/* logic/epf_pkg.sv */
// types shared by the ethernet port flow-control block
package epf_pkg;
  typedef struct packed {
    logic coll;
    logic unsup;
    logic ctl;
    logic len_err;
    logic crc;
    logic dribble;
    logic mii_err;
  } epf_rx_err_t;

  typedef struct packed {
    logic jabber;
    logic lost_carrier;
    logic excess_defer;
    logic late_coll;
    logic excess_coll;
    logic underrun;
    logic coll;
    logic deferred;
    logic heartbeat;
  } epf_tx_err_t;

  typedef struct packed {
    logic [7:0] rx_frame_status_byte3;
    logic [7:0] rx_frame_status_byte2;
    logic [7:0] rx_frame_status_byte1;
    logic [7:0] rx_frame_status_byte0;
  } epf_rx_stat_t;

  typedef struct packed {
    logic [7:0] tx_frame_status_hi;
    logic [7:0] tx_frame_status_lo;
  } epf_tx_stat_t;

  typedef enum logic [3:0] {
    RX_IDLE = 4'h1,
    RX_RECV = 4'h2,
    RX_JAM  = 4'h4,
    RX_DROP = 4'h8
  } epf_rx_state_t;
endpackage : epf_pkg

/* logic/epf_flow_ctl.sv */
// receive flow control, frame acceptance, tx retry and mii clocking
`timescale 1ns/1ps
`include "epf_cfg.svh"
// Behaviour
// (RQ1) automatic flow control is on after reset until host clears it
// (RQ2) pause and jam depend on the high threshold only; low is indication
// (RQ3) full duplex auto: one pause per frame received above high threshold
// (RQ4) pause frames carry destination 01-80-62-00-00-01
// (RQ5) software should set pause timer to 80 slots of 64 bytes
// (RQ6) software should set thresholds about 96 packets apart
// (RQ7) overflow sets a latched flag; frames dropped while overflow persists
// (RQ8) host writes to flow-control enable ignored during automatic control
// (RQ9) far-end pause frames honoured only when pause response control set
// (RQ10) tx queue gives threshold flags only, no automatic flow control
// (RQ11) half duplex: jam first 4 bytes of each new frame
// (RQ12) frame in progress at crossing not jammed; later frames jammed
// (RQ13) manual mode: host busy bit sends pause, jam request bit jams
// (RQ14) received pause frames flagged as control and unsupported in byte3
// (RQ15) strap pin selects rmii or mii mode
// (RQ16) mii dce mode makes 25 or 2.5 mhz tx and rx clocks from reference
// (RQ17) mii dte mode: phy drives tx and rx clocks, device does not
// (RQ18) max length from two bytes, capped at 2016
// (RQ19) frames above max length rejected; preamble not counted
// (RQ20) tx and rx status update as each frame completes
// (RQ21) tx errors set status and trigger retry per control bits
// (RQ22) errored frames rejected unless accepted; runts and collisions always
module epf_flow_ctl #(
  parameter int QW = 12
) (
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire logic                  reduced_iface_select_pin,
  input  wire logic                  dce_mode_pin,
  input  wire logic                  ref_clk,
  input  wire logic                  speed_100,
  input  wire logic                  full_duplex,
  input  wire logic                  auto_flow_wr,
  input  wire logic                  auto_flow_wdata,
  input  wire logic                  fce_wr,
  input  wire logic                  fce_wdata,
  input  wire logic                  fcb_set,
  input  wire logic                  jam_request_bit,
  input  wire logic                  pause_response_ctl,
  input  wire logic [15:0]           pause_timer,
  input  wire logic [QW-1:0]         rx_queue_level,
  input  wire logic [QW-1:0]         rx_queue_high_thresh,
  input  wire logic [QW-1:0]         rx_queue_low_thresh,
  input  wire logic                  rx_queue_full,
  input  wire logic                  ovf_clr,
  input  wire logic [QW-1:0]         tx_queue_level,
  input  wire logic [QW-1:0]         tx_queue_high_thresh,
  input  wire logic [QW-1:0]         tx_queue_low_thresh,
  input  wire logic [7:0]            max_rx_frame_len_hi,
  input  wire logic [7:0]            max_rx_frame_len_lo,
  input  wire logic [5:0]            rx_frame_reject_ctl,
  input  wire logic                  rx_sof,
  input  wire logic                  rx_byte_vld,
  input  wire logic                  rx_eof,
  input  wire epf_pkg::epf_rx_err_t  rx_err,
  input  wire logic                  tx_done,
  input  wire epf_pkg::epf_tx_err_t  tx_err,
  input  wire logic [6:0]            tx_frame_retry_ctl,
  input  wire logic [1:0]            heartbeat_retry_ctl,
  input  wire logic                  no_carrier_queue_flush,
  output logic                       auto_flow_ctl_en,
  output logic                       flow_ctl_enable_bit,
  output logic                       flow_ctl_busy_bit,
  output logic                       pause_req,
  output logic [15:0]                pause_timer_out,
  output logic [47:0]                pause_dest_addr,
  output logic                       far_pause_req,
  output logic                       jam_out,
  output logic                       rx_accept,
  output logic                       rx_reject,
  output logic                       rx_queue_overflow_flag,
  output logic                       rx_queue_above_high,
  output logic                       rx_queue_below_low,
  output logic                       tx_queue_above_high,
  output logic                       tx_queue_below_low,
  output epf_pkg::epf_rx_stat_t      rx_frame_status,
  output epf_pkg::epf_tx_stat_t      tx_frame_status,
  output logic                       tx_retry,
  output logic                       tx_flush,
  output logic                       rmii_mode,
  output logic                       dce_mode,
  output logic                       mii_tx_clk,
  output logic                       mii_rx_clk,
  output logic                       mii_clk_oe
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic over(input logic [QW-1:0] lvl, input logic [QW-1:0] thr);
    over = lvl > thr;
  endfunction : over

  // ------------------------------------------------------------
  // pin sampling, strap capture, dce clock generation
  // ------------------------------------------------------------
  logic [2:0] ref_s, rmii_s, dce_s, next_ref_s, next_rmii_s, next_dce_s;
  logic       ref_lvl, next_ref_lvl, next_rmii_mode, next_dce_mode;
  logic [1:0] strap_cnt, next_strap_cnt;
  logic [2:0] div_cnt, next_div_cnt;
  logic       next_tx_clk, next_rx_clk, next_clk_oe;

  always_comb begin
    next_ref_s = {ref_s[1:0], ref_clk};
    next_rmii_s = {rmii_s[1:0], reduced_iface_select_pin};
    next_dce_s = {dce_s[1:0], dce_mode_pin};
    // only the agreeing 2nd and 3rd stages count, the 1st may be metastable
    next_ref_lvl = (ref_s[1] == ref_s[2]) ? ref_s[2] : ref_lvl;
    next_strap_cnt = strap_cnt;
    next_rmii_mode = rmii_mode;
    next_dce_mode = dce_mode;
    if (strap_cnt != `EPF_STRAP_WAIT) begin
      next_strap_cnt = strap_cnt + 2'h1;
    end
    // reset clears the stages, so the pin reaches the third one only now; straps are static
    if (strap_cnt == `EPF_STRAP_WAIT) begin
      if (rmii_s[1] == rmii_s[2]) begin
        next_rmii_mode = rmii_s[2];  // [RQ15]
      end
      if (dce_s[1] == dce_s[2]) begin
        next_dce_mode = dce_s[2];
      end
    end
    next_div_cnt = div_cnt;
    next_tx_clk = mii_tx_clk;
    // dte: phy owns the clocks, so never drive them
    next_clk_oe = dce_mode & ~rmii_mode;  // [RQ16] [RQ17]
    if (next_ref_lvl != ref_lvl) begin
      if (speed_100) begin
        next_tx_clk = next_ref_lvl;  // [RQ16]
      end else if (next_ref_lvl) begin
        if (div_cnt == `EPF_DIV10_LAST) begin
          next_div_cnt = 3'h0;
          next_tx_clk = ~mii_tx_clk;  // [RQ16]
        end else begin
          next_div_cnt = div_cnt + 3'h1;
        end
      end
    end
    if (!next_clk_oe) begin
      next_tx_clk = 1'b0;
    end
    next_rx_clk = next_tx_clk;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ref_s <= 3'h0;
      rmii_s <= 3'h0;
      dce_s <= 3'h0;
      ref_lvl <= 1'b0;
      strap_cnt <= 2'h0;
      rmii_mode <= 1'b0;
      dce_mode <= 1'b0;
      div_cnt <= 3'h0;
      mii_tx_clk <= 1'b0;
      mii_rx_clk <= 1'b0;
      mii_clk_oe <= 1'b0;
    end else begin
      ref_s <= next_ref_s;
      rmii_s <= next_rmii_s;
      dce_s <= next_dce_s;
      ref_lvl <= next_ref_lvl;
      strap_cnt <= next_strap_cnt;
      rmii_mode <= next_rmii_mode;
      dce_mode <= next_dce_mode;
      div_cnt <= next_div_cnt;
      mii_tx_clk <= next_tx_clk;
      mii_rx_clk <= next_rx_clk;
      mii_clk_oe <= next_clk_oe;
    end
  end

  // ------------------------------------------------------------
  // flow control, receive acceptance, transmit status
  // ------------------------------------------------------------
  epf_pkg::epf_rx_state_t rx_state, next_rx_state;
  epf_pkg::epf_rx_stat_t  next_rx_stat;
  epf_pkg::epf_tx_stat_t  next_tx_stat;
  logic [15:0] len, next_len, max_len;
  logic [2:0]  jam_cnt, next_jam_cnt;
  logic        above, runt, too_long, bad, retry;
  logic        next_auto, next_fce, next_busy, next_pause, next_far, next_jam;
  logic        next_acc, next_rej, next_ovf, next_retry, next_flush;

  always_comb begin
    above = over(rx_queue_level, rx_queue_high_thresh);  // [RQ2]
    // anything above 2016 is unpredictable, so clamp rather than trust it
    max_len = {max_rx_frame_len_hi, max_rx_frame_len_lo};  // [RQ18]
    if (max_len > `EPF_MAX_LEN_CAP) begin
      max_len = `EPF_MAX_LEN_CAP;  // [RQ18]
    end
    next_auto = auto_flow_wr ? auto_flow_wdata : auto_flow_ctl_en;  // [RQ1]
    next_fce = next_auto ? 1'b1 : (fce_wr ? fce_wdata : flow_ctl_enable_bit);  // [RQ8]
    next_busy = fcb_set & ~auto_flow_ctl_en | flow_ctl_busy_bit;
    next_pause = 1'b0;
    next_far = 1'b0;
    next_acc = 1'b0;
    next_rej = 1'b0;
    next_ovf = ovf_clr ? 1'b0 : rx_queue_overflow_flag;
    next_rx_state = rx_state;
    next_len = len;
    next_jam_cnt = jam_cnt;
    next_rx_stat = rx_frame_status;
    runt = len < `EPF_RUNT_BYTES;
    too_long = len > max_len;  // [RQ19]
    bad = |(rx_err[5:0] & ~rx_frame_reject_ctl) | rx_err.coll | runt;  // [RQ22]
    bad = bad | too_long | (rx_state == epf_pkg::RX_JAM);  // [RQ19]
    if (flow_ctl_busy_bit && !auto_flow_ctl_en && full_duplex
        && rx_state != epf_pkg::RX_DROP) begin
      next_pause = 1'b1;  // [RQ13]
      next_busy = fcb_set;
    end
    case (rx_state)
      epf_pkg::RX_IDLE: begin
        if (rx_sof) begin
          next_len = 16'h0;
          next_jam_cnt = 3'h0;
          if (rx_queue_full) begin
            next_ovf = 1'b1;  // [RQ7]
            next_rx_state = epf_pkg::RX_DROP;
          end else if (!full_duplex && (auto_flow_ctl_en ? above : jam_request_bit)) begin
            // decided at frame start so the frame in flight is never jammed
            next_rx_state = epf_pkg::RX_JAM;  // [RQ11] [RQ12] [RQ13]
          end else begin
            next_rx_state = epf_pkg::RX_RECV;
          end
        end
      end
      epf_pkg::RX_RECV, epf_pkg::RX_JAM: begin
        if (rx_byte_vld && len != `EPF_LEN_SAT) begin
          next_len = len + 16'h1;  // [RQ19]
        end
        if (rx_byte_vld && jam_cnt != `EPF_JAM_BYTES) begin
          next_jam_cnt = jam_cnt + 3'h1;
        end
        if (rx_eof) begin
          next_rx_state = epf_pkg::RX_IDLE;
          next_acc = ~bad;  // [RQ22]
          next_rej = bad;
          if (full_duplex && auto_flow_ctl_en && above) begin
            next_pause = 1'b1;  // [RQ3]
          end
          next_far = rx_err.ctl & pause_response_ctl & full_duplex;  // [RQ9]
          next_rx_stat.rx_frame_status_byte0 = {1'b0, too_long, runt, rx_err.coll,
                                                rx_err.len_err, rx_err.crc,
                                                rx_err.dribble, rx_err.mii_err};  // [RQ20]
          next_rx_stat.rx_frame_status_byte1 = len[7:0];
          next_rx_stat.rx_frame_status_byte2 = len[15:8];
          next_rx_stat.rx_frame_status_byte3 = {4'h0, rx_state == epf_pkg::RX_JAM,
                                                1'b0, rx_err.ctl, rx_err.unsup};  // [RQ14]
        end
      end
      epf_pkg::RX_DROP: begin
        if (rx_eof) begin
          next_rx_state = epf_pkg::RX_IDLE;
          next_rej = 1'b1;  // [RQ7]
          next_rx_stat.rx_frame_status_byte3 = {6'h0, rx_err.ctl, rx_err.unsup};
          next_rx_stat.rx_frame_status_byte3[2] = 1'b1;
        end
      end
      default: begin
        next_rx_state = epf_pkg::RX_IDLE;
      end
    endcase
    next_jam = (next_rx_state == epf_pkg::RX_JAM) && (next_jam_cnt != `EPF_JAM_BYTES);  // [RQ11]
    retry = |({tx_err.jabber, tx_err.lost_carrier, tx_err.excess_defer, tx_err.late_coll,
               tx_err.excess_coll, tx_err.underrun, tx_err.coll} & tx_frame_retry_ctl);
    retry = retry | |({tx_err.deferred, tx_err.heartbeat} & heartbeat_retry_ctl);  // [RQ21]
    next_tx_stat = tx_frame_status;
    next_retry = 1'b0;
    next_flush = 1'b0;
    if (tx_done) begin
      next_tx_stat = {7'h0, tx_err};  // [RQ20] [RQ21]
      next_retry = retry;  // [RQ21]
      next_flush = tx_err.lost_carrier & no_carrier_queue_flush;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      auto_flow_ctl_en <= 1'b1;
      flow_ctl_enable_bit <= 1'b1;
      flow_ctl_busy_bit <= 1'b0;
      pause_req <= 1'b0;
      pause_timer_out <= 16'h0;
      pause_dest_addr <= `EPF_PAUSE_DA;
      far_pause_req <= 1'b0;
      jam_out <= 1'b0;
      rx_accept <= 1'b0;
      rx_reject <= 1'b0;
      rx_queue_overflow_flag <= 1'b0;
      rx_queue_above_high <= 1'b0;
      rx_queue_below_low <= 1'b0;
      tx_queue_above_high <= 1'b0;
      tx_queue_below_low <= 1'b0;
      rx_frame_status <= '0;
      tx_frame_status <= '0;
      tx_retry <= 1'b0;
      tx_flush <= 1'b0;
      rx_state <= epf_pkg::RX_IDLE;
      len <= 16'h0;
      jam_cnt <= 3'h0;
    end else begin
      auto_flow_ctl_en <= next_auto;
      flow_ctl_enable_bit <= next_fce;
      flow_ctl_busy_bit <= next_busy;
      pause_req <= next_pause;
      pause_timer_out <= pause_timer;
      pause_dest_addr <= `EPF_PAUSE_DA;  // [RQ4]
      far_pause_req <= next_far;
      jam_out <= next_jam;
      rx_accept <= next_acc;
      rx_reject <= next_rej;
      rx_queue_overflow_flag <= next_ovf;
      rx_queue_above_high <= above;
      rx_queue_below_low <= over(rx_queue_low_thresh, rx_queue_level);  // [RQ2]
      tx_queue_above_high <= over(tx_queue_level, tx_queue_high_thresh);  // [RQ10]
      tx_queue_below_low <= over(tx_queue_low_thresh, tx_queue_level);  // [RQ10]
      rx_frame_status <= next_rx_stat;
      tx_frame_status <= next_tx_stat;
      tx_retry <= next_retry;
      tx_flush <= next_flush;
      rx_state <= next_rx_state;
      len <= next_len;
      jam_cnt <= next_jam_cnt;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_auto_rst;
    @(posedge mclk) !$past(rst_n) && rst_n |-> auto_flow_ctl_en;
  endproperty
  a_auto_rst: assert property (p_auto_rst) else $error("auto flow off after reset"); // [RQ1]

  property p_fce_lock;
    @(posedge mclk) disable iff (!rst_n)
      auto_flow_ctl_en && !auto_flow_wr && fce_wr && !fce_wdata |=> flow_ctl_enable_bit;
  endproperty
  a_fce_lock: assert property (p_fce_lock) else $error("fce changed in auto mode"); // [RQ8]

  property p_auto_pause;
    @(posedge mclk) disable iff (!rst_n)
      rx_state == epf_pkg::RX_RECV && rx_eof && full_duplex && auto_flow_ctl_en && above
      |=> pause_req && pause_dest_addr == `EPF_PAUSE_DA;
  endproperty
  a_auto_pause: assert property (p_auto_pause) else $error("missing pause frame"); // [RQ3]

  property p_pause_da;
    @(posedge mclk) disable iff (!rst_n) pause_req |-> pause_dest_addr == `EPF_PAUSE_DA;
  endproperty
  a_pause_da: assert property (p_pause_da) else $error("wrong pause address"); // [RQ4]

  property p_ovf;
    @(posedge mclk) disable iff (!rst_n)
      rx_state == epf_pkg::RX_IDLE && rx_sof && rx_queue_full
      |=> rx_queue_overflow_flag && rx_state == epf_pkg::RX_DROP;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not flagged"); // [RQ7]

  property p_jam_start;
    @(posedge mclk) disable iff (!rst_n)
      rx_state == epf_pkg::RX_IDLE && rx_sof && !rx_queue_full && !full_duplex
      && auto_flow_ctl_en && above |=> jam_out ##0 rx_state == epf_pkg::RX_JAM;
  endproperty
  a_jam_start: assert property (p_jam_start) else $error("frame not jammed"); // [RQ11]

  property p_no_jam_fd;
    @(posedge mclk) disable iff (!rst_n) full_duplex && $stable(full_duplex) |=> !jam_out;
  endproperty
  a_no_jam_fd: assert property (p_no_jam_fd) else $error("jam in full duplex"); // [RQ11]

  property p_runt;
    @(posedge mclk) disable iff (!rst_n)
      rx_state != epf_pkg::RX_IDLE && rx_eof && len < `EPF_RUNT_BYTES |=> rx_reject && !rx_accept;
  endproperty
  a_runt: assert property (p_runt) else $error("runt accepted"); // [RQ22]

  property p_tx_retry;
    @(posedge mclk) disable iff (!rst_n)
      tx_done && tx_err.underrun && tx_frame_retry_ctl[1] |=> tx_retry;
  endproperty
  a_tx_retry: assert property (p_tx_retry) else $error("no retry on underrun"); // [RQ21]
endmodule : epf_flow_ctl

/* verification/epf_phy_model.sv */
// far-side receive model: frame strobes and a free-running reference clock
`timescale 1ns/1ps
module epf_phy_model (
  input  wire logic            mclk,
  output logic                 ref_clk,
  output logic                 rx_sof,
  output logic                 rx_byte_vld,
  output logic                 rx_eof,
  output epf_pkg::epf_rx_err_t rx_err
);
  initial begin
    ref_clk = 1'b0;
    rx_sof = 1'b0;
    rx_byte_vld = 1'b0;
    rx_eof = 1'b0;
    rx_err = '1;
  end

  // --------------------------------------------------------------
  // reference clock
  // --------------------------------------------------------------
  // odd offset keeps each reference edge 0.7 ns ahead of an mclk rising edge
  initial begin
    #1.3;
    forever #16 ref_clk = ~ref_clk;
  end

  // --------------------------------------------------------------
  // frame sender
  // --------------------------------------------------------------
  task automatic send_frame(input int nbytes, input epf_pkg::epf_rx_err_t err);
    @(negedge mclk);
    rx_sof = 1'b1;
    @(negedge mclk);
    rx_sof = 1'b0;
    for (int i = 0; i < nbytes; i++) begin
      rx_byte_vld = 1'b1; // preamble and sfd already stripped
      @(negedge mclk);
    end
    rx_byte_vld = 1'b0;
    rx_eof = 1'b1;
    rx_err = err;
    @(negedge mclk);
    rx_eof = 1'b0;
    rx_err = ~err; // error lines are stale outside eof
  endtask : send_frame
endmodule : epf_phy_model

/* verification/test_epf_flow_ctl.sv */
// self-checking bench for the ethernet port flow-control block
`timescale 1ns/1ps
module test_epf_flow_ctl;
  logic mclk, rst_n, rmii_pin, dce_pin, spd, fdx, af_wr, af_wd, fce_wr, fce_wd, fcb_set;
  logic jam_req, prc, rx_full, ovf_clr, tx_done, nc_flush, ref_clk, rx_sof, rx_vld, rx_eof;
  logic afe, fce, fcb, pause, far, jam, acc, rej, ovf, rq_hi, rq_lo, tq_hi, tq_lo;
  logic retry, flush, rmii_m, dce_m, txc, rxc, coe, txc_q;
  logic [15:0] ptim, ptim_out, mx;
  logic [47:0] pda;
  logic [11:0] rq_lvl, rq_hth, rq_lth, tq_lvl, tq_hth, tq_lth;
  logic [5:0]  rej_ctl;
  logic [6:0]  rty_ctl;
  logic [1:0]  hb_ctl;
  logic [8:0]  txe;
  epf_pkg::epf_rx_err_t  rx_err;
  epf_pkg::epf_tx_err_t  tx_err;
  epf_pkg::epf_rx_stat_t rx_st;
  epf_pkg::epf_tx_stat_t tx_st;
  int num_errors, total_checks, n_acc, n_rej, n_pause, n_far, n_jam, n_rty, n_fl, n_tgl;
  int lens[6] = '{63, 64, 100, 101, 2016, 2017};

  epf_phy_model i_epf_phy_model (.mclk(mclk), .ref_clk(ref_clk), .rx_sof(rx_sof),
    .rx_byte_vld(rx_vld), .rx_eof(rx_eof), .rx_err(rx_err));

  epf_flow_ctl #(.QW(12)) i_epf_flow_ctl (.mclk(mclk), .rst_n(rst_n),
    .reduced_iface_select_pin(rmii_pin), .dce_mode_pin(dce_pin), .ref_clk(ref_clk),
    .speed_100(spd), .full_duplex(fdx), .auto_flow_wr(af_wr), .auto_flow_wdata(af_wd),
    .fce_wr(fce_wr), .fce_wdata(fce_wd), .fcb_set(fcb_set), .jam_request_bit(jam_req),
    .pause_response_ctl(prc), .pause_timer(ptim), .rx_queue_level(rq_lvl),
    .rx_queue_high_thresh(rq_hth), .rx_queue_low_thresh(rq_lth), .rx_queue_full(rx_full),
    .ovf_clr(ovf_clr), .tx_queue_level(tq_lvl), .tx_queue_high_thresh(tq_hth),
    .tx_queue_low_thresh(tq_lth), .max_rx_frame_len_hi(mx[15:8]), .max_rx_frame_len_lo(mx[7:0]),
    .rx_frame_reject_ctl(rej_ctl), .rx_sof(rx_sof), .rx_byte_vld(rx_vld), .rx_eof(rx_eof),
    .rx_err(rx_err), .tx_done(tx_done), .tx_err(tx_err), .tx_frame_retry_ctl(rty_ctl),
    .heartbeat_retry_ctl(hb_ctl), .no_carrier_queue_flush(nc_flush), .auto_flow_ctl_en(afe),
    .flow_ctl_enable_bit(fce), .flow_ctl_busy_bit(fcb), .pause_req(pause),
    .pause_timer_out(ptim_out), .pause_dest_addr(pda), .far_pause_req(far), .jam_out(jam),
    .rx_accept(acc), .rx_reject(rej), .rx_queue_overflow_flag(ovf), .rx_queue_above_high(rq_hi),
    .rx_queue_below_low(rq_lo), .tx_queue_above_high(tq_hi), .tx_queue_below_low(tq_lo),
    .rx_frame_status(rx_st), .tx_frame_status(tx_st), .tx_retry(retry), .tx_flush(flush),
    .rmii_mode(rmii_m), .dce_mode(dce_m), .mii_tx_clk(txc), .mii_rx_clk(rxc), .mii_clk_oe(coe));

  // --------------------------------------------------------------
  // clock and event counters
  // --------------------------------------------------------------
  initial mclk = 1'b0;
  always #2 mclk = ~mclk;

  // pulses are counted, so checks do not hinge on their exact cycle
  always @(posedge mclk) begin
    n_acc += int'(acc === 1'b1);
    n_rej += int'(rej === 1'b1);
    n_pause += int'(pause === 1'b1);
    n_far += int'(far === 1'b1);
    n_jam += int'(jam === 1'b1 && rx_vld === 1'b1);
    n_rty += int'(retry === 1'b1);
    n_fl += int'(flush === 1'b1);
    n_tgl += int'(txc !== txc_q);
    txc_q = txc;
  end

  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic clr();
    {n_acc, n_rej, n_pause, n_far, n_jam, n_rty, n_fl, n_tgl} = '0;
  endtask : clr

  task automatic frame(input int n, input logic [6:0] e);
    clr();
    i_epf_phy_model.send_frame(n, epf_pkg::epf_rx_err_t'(e));
    repeat (4) @(negedge mclk);
  endtask : frame

  task automatic wr_auto(input logic v);
    af_wd = v;
    af_wr = 1'b1;
    @(negedge mclk);
    af_wr = 1'b0;
    @(negedge mclk);
  endtask : wr_auto

  task automatic wr_fce(input logic v);
    fce_wd = v;
    fce_wr = 1'b1;
    @(negedge mclk);
    fce_wr = 1'b0;
    @(negedge mclk);
  endtask : wr_fce

  task automatic pulse_fcb();
    clr();
    fcb_set = 1'b1;
    @(negedge mclk);
    fcb_set = 1'b0;
    repeat (6) @(negedge mclk);
  endtask : pulse_fcb

  task automatic stop_test();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  // --------------------------------------------------------------
  // watchdog
  // --------------------------------------------------------------
  initial begin
    #100000;
    num_errors++;
    stop_test();
  end

  // --------------------------------------------------------------
  // test sequence
  // --------------------------------------------------------------
  initial begin
    {rst_n, rmii_pin, spd, af_wr, af_wd, fce_wr, fce_wd, fcb_set, jam_req, prc} = '0;
    {rx_full, ovf_clr, tx_done, tx_err, rej_ctl, rty_ctl, hb_ctl, txc_q} = '0;
    {dce_pin, fdx, nc_flush} = 3'h7;
    {num_errors, total_checks} = '0;
    ptim = 16'h0050; // 80 slots of 64 bytes
    rq_hth = 12'h100;
    rq_lth = 12'h0a0; // 96 below the high threshold
    {rq_lvl, tq_lvl, tq_hth, tq_lth} = {12'h0c0, 12'h010, 12'h008, 12'h020};
    mx = 16'h0800;
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    chk(48'(afe), 48'h1);
    chk(pda, 48'h0180_6200_0001);
    repeat (6) @(negedge mclk);
    chk(48'({rmii_m, dce_m, coe}), 48'h3);
    chk(48'({tq_hi, tq_lo}), 48'h3);
    wr_fce(1'b0);
    chk(48'(fce), 48'h1);
    pulse_fcb();
    chk(48'(n_pause), 48'h0);
    frame(64, 7'h00);
    chk(48'({n_acc, n_pause}), {16'h1, 32'h0});
    chk(48'(rx_st), 48'h0000_4000);
    rq_lvl = 12'h101;
    for (int k = 0; k < 2; k++) begin
      rq_lth = k ? 12'h200 : 12'h0a0;
      frame(64, 7'h00);
      chk(48'(n_pause), 48'h1);
      chk(48'({ptim_out, rq_hi, rq_lo}), {30'h0, 16'h0050, 1'b1, 1'(k)});
    end
    rq_lvl = 12'h0c0;
    for (int i = 0; i < 6; i++) begin
      mx = (i < 4) ? 16'h0064 : 16'h0800;
      frame(lens[i], 7'h00);
      chk(48'(n_acc), 48'(i == 1 || i == 2 || i == 4));
      chk(48'(rx_st), {16'h0, 8'h00, 16'(lens[i]), (i == 0) ? 8'h20
          : (i == 3 || i == 5) ? 8'h40 : 8'h00});
    end
    for (int j = 0; j < 12; j++) begin
      rej_ctl = (j % 2) ? 6'(1 << (j / 2)) : 6'h00;
      frame(64, 7'(1 << (j / 2)));
      chk(48'(n_acc), 48'(j % 2));
    end
    rej_ctl = 6'h3f;
    frame(64, 7'h40);
    chk(48'(n_rej), 48'h1);
    for (int k = 0; k < 2; k++) begin
      prc = 1'(k);
      frame(64, 7'h30);
      chk(48'({n_far, rx_st.rx_frame_status_byte3}), {40'(k), 8'h03});
    end
    rx_full = 1'b1;
    frame(64, 7'h00);
    chk(48'({n_rej, ovf, rx_st.rx_frame_status_byte3}), {39'h1, 1'b1, 8'h04});
    rx_full = 1'b0;
    frame(64, 7'h00);
    chk(48'({n_acc, ovf}), {47'h1, 1'b1});
    ovf_clr = 1'b1;
    @(negedge mclk);
    ovf_clr = 1'b0;
    @(negedge mclk);
    chk(48'(ovf), 48'h0);
    fdx = 1'b0;
    clr();
    fork
      i_epf_phy_model.send_frame(64, '0);
      begin
        repeat (20) @(negedge mclk);
        rq_lvl = 12'h101;
      end
    join
    repeat (4) @(negedge mclk);
    chk(48'({n_jam, n_acc}), {32'h0, 16'h1});
    frame(64, 7'h00);
    chk({16'(n_jam), 16'(n_rej), 16'(n_pause)}, {16'h4, 16'h1, 16'h0});
    rq_lvl = 12'h0c0;
    frame(64, 7'h00);
    chk(48'({n_jam, n_acc}), {32'h0, 16'h1});
    wr_auto(1'b0);
    chk(48'(afe), 48'h0);
    wr_fce(1'b0);
    chk(48'(fce), 48'h0);
    jam_req = 1'b1;
    frame(64, 7'h00);
    chk(48'(n_jam), 48'h4);
    {jam_req, fdx, rq_lvl} = {1'b0, 1'b1, 12'h101};
    frame(64, 7'h00);
    chk(48'(n_pause), 48'h0);
    pulse_fcb();
    chk(48'({n_pause, fcb}), {47'h1, 1'b0});
    for (int t = 0; t < 4; t++) begin
      txe = (t == 3) ? 9'h001 : (t == 2) ? 9'h080 : 9'h008;
      {rty_ctl, hb_ctl} = (t == 0) ? 9'h008 : (t == 3) ? 9'h001 : 9'h000;
      clr();
      tx_err = epf_pkg::epf_tx_err_t'(txe);
      tx_done = 1'b1;
      @(negedge mclk);
      {tx_done, tx_err} = {1'b0, ~txe};
      repeat (3) @(negedge mclk);
      chk(48'({n_rty, n_fl}), {16'(t == 0 || t == 3), 32'(t == 2)});
      chk(48'(tx_st), {32'h0, 7'h0, txe});
    end
    for (int s = 0; s < 2; s++) begin
      spd = 1'(1 - s);
      repeat (60) @(negedge mclk);
      clr();
      repeat (400) @(negedge mclk);
      chk(48'(n_tgl >= (s ? 8 : 97) && n_tgl <= (s ? 12 : 103)), 48'h1);
      chk(48'({coe, rxc ^ txc}), 48'h2);
    end
    {rst_n, dce_pin} = 2'h0;
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    repeat (6) @(negedge mclk);
    chk(48'({afe, dce_m, coe, txc, rxc}), 48'h10);
    stop_test();
  end
endmodule : test_epf_flow_ctl
